// ==== core/rs485_ctrl_pkg.sv ====
// shared constants and carriers for the rs-485 / multidrop control block
package rs485_ctrl_pkg;

  // register byte offsets on the apb window
  localparam logic [7:0] EFC_OFFSET    = 8'h00;
  localparam logic [7:0] CTL_OFFSET    = 8'h04;
  localparam logic [7:0] MATCH_OFFSET  = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;

  // extra_features_control field positions
  localparam int IRDA_MODE_BIT  = 7;
  localparam int DIR_INVERT_BIT = 5;
  localparam int DIR_CTRL_BIT   = 4;
  localparam int TX_OFF_BIT     = 2;
  localparam int RX_OFF_BIT     = 1;
  localparam int MULTIDROP_BIT  = 0;
  localparam logic [7:0] EFC_WRITE_MASK = 8'hb7;
  localparam logic [7:0] EFC_RESET      = 8'h00;

  // control register field positions
  localparam int MODEM_RTS_BIT   = 0;
  localparam int HW_FLOW_BIT     = 1;
  localparam int SPECIAL_EN_BIT  = 2;
  localparam int LINE_IE_BIT     = 3;
  localparam int SOFT_RESET_BIT  = 7;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h0f;
  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [7:0] MATCH_RESET    = 8'h00;

  // status register field positions
  localparam int ST_RX_ACTIVE_BIT = 0;
  localparam int ST_RTS_BIT       = 1;
  localparam int ST_TX_PEND_BIT   = 2;
  localparam int ST_SPECIAL_BIT   = 3;
  localparam int ST_ADDR_BIT      = 4;

  // infrared pulse format limit, in bit/s
  localparam int SIR_MAX_RATE_BPS = 115200;

  // rts pin idle level after reset (modem bit clear gives high)
  localparam logic RTS_N_RESET = 1'b1;

  // character from the receiver with its ninth bit
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_char_s;

  // entry pushed into the receive fifo
  typedef struct packed {
    logic       parity_err;
    logic [7:0] data;
  } rx_entry_s;

endpackage : rs485_ctrl_pkg

// ==== core/rs485_dir_ctrl.sv ====
// rts pin source selection and automatic rs-485 direction drive
module rs485_dir_ctrl (
  input  wire logic clk,           // core clock
  input  wire logic rst,           // synchronous reset, high
  input  wire logic tx_push,       // host wrote the transmit fifo
  input  wire logic tx_fifo_empty, // transmit fifo holds nothing
  input  wire logic tx_shift_busy, // shift register still sending
  input  wire logic dir_en,        // transmitter owns rts
  input  wire logic invert,        // reverse direction polarity
  input  wire logic modem_rts,     // modem control rts bit
  input  wire logic hw_flow_en,    // hardware flow control on
  input  wire logic flow_rts_n,    // level from flow control logic
  output logic      rts_n_q,       // rts pin level
  output logic      tx_pend_q      // transmit data pending
);

  logic pending;

  // a push counts at once so the driver turns before the first bit
  assign pending = tx_push | ~tx_fifo_empty | tx_shift_busy;

  // pending flag kept for status readback
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_pend_q <= 1'b0;
    end else begin
      tx_pend_q <= pending;
    end
  end

  // pin level; direction ownership beats modem bit and flow control
  always_ff @(posedge clk) begin
    if (rst) begin
      rts_n_q <= rs485_ctrl_pkg::RTS_N_RESET;
    // R8: direction overrides all
    end else if (dir_en) begin
      // R9: low while pending
      // R11: inverted drive high
      rts_n_q <= invert ? pending : ~pending;
    // R3: transmitter off rts
    end else if (hw_flow_en) begin
      rts_n_q <= flow_rts_n;
    end else begin
      rts_n_q <= ~modem_rts;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence push_in_auto_s;
    dir_en && !invert && tx_push;
  endsequence

  rts_turn_low_a: assert property (push_in_auto_s |=> !rts_n_q) // R9
    else $error("rts not low after push in direction mode");
  rts_invert_a: assert property (dir_en && invert && $past(dir_en && invert) |-> rts_n_q == tx_pend_q) // R11
    else $error("inverted rts disagrees with pending");

endmodule : rs485_dir_ctrl

// ==== core/multidrop_filter.sv ====
// per-character store, drop and flag decisions for the receive path
module multidrop_filter (
  input  wire logic                     clk,        // core clock
  input  wire logic                     rst,        // synchronous reset, high
  input  wire logic                     rx_valid,   // character complete
  input  wire rs485_ctrl_pkg::rx_char_s rx_char,    // character and ninth bit
  input  wire logic                     rx_par_err, // core parity check result
  input  wire logic                     multidrop,  // 9-bit mode on
  input  wire logic                     special_en, // special character detect
  input  wire logic                     rx_off,     // receiver off bit
  input  wire logic                     line_ie,    // line status interrupt enable
  input  wire logic [7:0]               match_char, // station address / special char
  input  wire logic                     auto_clear, // software turned receiver off, or soft reset
  output logic                          push_q,     // store into receive fifo
  output rs485_ctrl_pkg::rx_entry_s     entry_q,    // stored entry
  output logic                          line_evt_q, // line status interrupt pulse
  output logic                          special_q,  // special character seen pulse
  output logic                          addr_q,     // address character seen pulse
  output logic                          auto_on_q   // receiver on in auto address mode
);

  logic store;
  logic pe;
  logic hit;
  logic is_addr;

  assign hit     = rx_char.data == match_char;
  assign is_addr = multidrop & rx_char.ninth;

  // decision per character
  always_comb begin
    store = 1'b0;
    pe    = 1'b0;
    if (!multidrop) begin
      store = ~rx_off;
      pe    = rx_par_err;
    end else if (!special_en) begin
      // R15: off drops data
      // R17: address flags again
      store = rx_char.ninth | ~rx_off;
      pe    = rx_char.ninth;
    end else begin
      // R18: drop unmatched
      // R19: matched address stored
      store = rx_char.ninth ? hit : auto_on_q;
      pe    = rx_char.ninth;
    end
  end

  // registered fifo push and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      push_q     <= 1'b0;
      entry_q    <= '0;
      line_evt_q <= 1'b0;
      special_q  <= 1'b0;
      addr_q     <= 1'b0;
    end else begin
      push_q     <= rx_valid & store;
      entry_q    <= '{parity_err: pe, data: rx_char.data};
      // R12: address tells host
      line_evt_q <= rx_valid & store & pe & line_ie;
      addr_q     <= rx_valid & store & is_addr;
      // R21: special match flagged
      special_q  <= rx_valid & ~multidrop & special_en & hit & store;
    end
  end

  // auto address receiver state; a matching address beats a software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      auto_on_q <= 1'b0;
    // R19: match enables receiver
    end else if (rx_valid && multidrop && special_en && rx_char.ninth && hit) begin
      auto_on_q <= 1'b1;
    // R20: mismatch disables receiver
    end else if ((rx_valid && multidrop && special_en && rx_char.ninth) || auto_clear) begin
      auto_on_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence auto_addr_s(logic m);
    rx_valid && multidrop && special_en && rx_char.ninth && (hit == m);
  endsequence

  auto_match_a: assert property (auto_addr_s(1'b1) |=> push_q && entry_q.parity_err && auto_on_q) // R19
    else $error("matched address not stored or receiver not enabled");
  auto_miss_a: assert property (auto_addr_s(1'b0) |=> !push_q && !auto_on_q) // R20
    else $error("unmatched address not dropped");
  host_off_data_a: assert property (rx_valid && multidrop && !special_en && rx_off && !rx_char.ninth |=> !push_q) // R15
    else $error("data byte stored while receiver off");

endmodule : multidrop_filter

// ==== core/rs485_multidrop_ctrl.sv ====
// extra features control: infrared select, tx/rx gating, rts direction, multidrop receive
// Operation
// R1: bit 7 zero selects 3/16 infrared pulse
// R2: bit 5 sets rts polarity in rs-485
// R3: bit 4 hands rts to transmitter
// R4: bit 2 stops sending, fifo still fills
// R5: bit 1 stops reception, held char flushed
// R6: software avoids receiver off mid-character
// R7: bit 0 enables 9-bit multidrop mode
// R8: direction control overrides modem and flow rts
// R9: rts low on push, high after last bit
// R10: software disables hardware flow before auto rts
// R11: inverted: rts high pending, low after
// R12: ninth bit one marks address, host told
// R13: software disables all flow control for multidrop
// R14: software sets forced-zero parity for host mode
// R15: receiver off: data dropped, address flagged, stored
// R16: software enables receiver on own address
// R17: enabled receiver flags next address again
// R18: auto mode discards data and unmatched addresses
// R19: matched address enables receiver, stored flagged
// R20: later unmatched address disables receiver, dropped
// R21: special character match stored and flagged
// R22: reserved bits 6 and 3 read zero
// R23: register clears to zero on any reset
//
// The APB interface to the registers and the address map were decided locally.
module rs485_multidrop_ctrl (
  input  wire logic                     clk,           // core clock
  input  wire logic                     rst,           // synchronous reset, high
  input  wire logic                     psel,          // apb select
  input  wire logic                     penable,       // apb access phase
  input  wire logic                     pwrite,        // apb direction
  input  wire logic [7:0]               paddr,         // apb byte address
  input  wire logic [31:0]              pwdata,        // apb write data
  output logic      [31:0]              prdata,        // apb read data
  output logic                          pready,        // apb ready
  output logic                          pslverr,       // apb error, unmapped address
  input  wire logic                     tx_push,       // host wrote the transmit fifo
  input  wire logic                     tx_fifo_empty, // transmit fifo empty
  input  wire logic                     tx_shift_busy, // shift register sending
  input  wire logic                     flow_rts_n,    // rts level from flow control
  input  wire logic                     rx_valid,      // received character complete
  input  wire rs485_ctrl_pkg::rx_char_s rx_char,       // received character
  input  wire logic                     rx_par_err,    // core parity check result
  output logic                          rts_n,         // rts pin
  output logic                          irda_sir_sel,  // 3/16 pulse infrared format
  output logic                          tx_allow,      // shift register may load
  output logic                          rx_sample_en,  // receiver samples the line
  output logic                          rx_flush,      // move held character to fifo
  output logic                          rx_push,       // receive fifo write
  output rs485_ctrl_pkg::rx_entry_s     rx_entry,      // receive fifo entry
  output logic                          line_evt       // line status interrupt pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] efc_q;
  logic [7:0] efc_d;
  logic [7:0] ctl_q;
  logic [7:0] match_q;
  logic       special_flag_q;
  logic       addr_flag_q;
  logic       tx_pend;
  logic       special_evt;
  logic       addr_evt;
  logic       auto_on;
  logic       wr_acc;
  logic       rd_acc;
  logic       soft_rst;
  logic       rx_active;

  // decode used by the error flag only; the read mux decodes with its own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == rs485_ctrl_pkg::EFC_OFFSET || a == rs485_ctrl_pkg::CTL_OFFSET ||
             a == rs485_ctrl_pkg::MATCH_OFFSET || a == rs485_ctrl_pkg::STATUS_OFFSET;
  endfunction : mapped

  // one wait state: the answer is computed in the first access cycle
  assign wr_acc   = psel & penable & pready & pwrite;
  assign rd_acc   = psel & penable & ~pready & ~pwrite;
  assign soft_rst = wr_acc & (paddr == rs485_ctrl_pkg::CTL_OFFSET) &
                    pwdata[rs485_ctrl_pkg::SOFT_RESET_BIT];

  // next value of the extra features register
  always_comb begin
    efc_d = efc_q;
    // R23: soft reset clears
    if (soft_rst) begin
      efc_d = rs485_ctrl_pkg::EFC_RESET;
    end else if (wr_acc && paddr == rs485_ctrl_pkg::EFC_OFFSET) begin
      // R22: reserved stay zero
      efc_d = pwdata[7:0] & rs485_ctrl_pkg::EFC_WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  // ready pulse and error flag
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
    end
  end

  // read data captured on the same edge that raises ready
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_acc) begin
      unique case (paddr)
        rs485_ctrl_pkg::EFC_OFFSET:    prdata <= {24'h000000, efc_q};
        rs485_ctrl_pkg::CTL_OFFSET:    prdata <= {24'h000000, ctl_q};
        rs485_ctrl_pkg::MATCH_OFFSET:  prdata <= {24'h000000, match_q};
        rs485_ctrl_pkg::STATUS_OFFSET: prdata <= {27'h0000000, addr_flag_q, special_flag_q,
                                                  tx_pend, rts_n, rx_active};
        default:                       prdata <= '0;
      endcase
    end
  end

  // extra features register
  always_ff @(posedge clk) begin
    if (rst) begin
      efc_q <= rs485_ctrl_pkg::EFC_RESET;
    end else begin
      efc_q <= efc_d;
    end
  end

  // control and match registers; soft reset leaves match_q alone, and its own write loads ctl_q from the low bits
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_q   <= rs485_ctrl_pkg::CTL_RESET;
      match_q <= rs485_ctrl_pkg::MATCH_RESET;
    end else if (wr_acc && paddr == rs485_ctrl_pkg::CTL_OFFSET) begin
      ctl_q   <= pwdata[7:0] & rs485_ctrl_pkg::CTL_WRITE_MASK;
    end else if (wr_acc && paddr == rs485_ctrl_pkg::MATCH_OFFSET) begin
      match_q <= pwdata[7:0];
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      special_flag_q <= 1'b0;
      addr_flag_q    <= 1'b0;
    end else begin
      // R21: special flag sticky
      special_flag_q <= special_evt | (special_flag_q & ~(wr_acc &&
                        paddr == rs485_ctrl_pkg::STATUS_OFFSET &&
                        pwdata[rs485_ctrl_pkg::ST_SPECIAL_BIT]));
      addr_flag_q    <= addr_evt | (addr_flag_q & ~(wr_acc &&
                        paddr == rs485_ctrl_pkg::STATUS_OFFSET &&
                        pwdata[rs485_ctrl_pkg::ST_ADDR_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit and receive gating

  // gate outputs follow the next register value so they never lag it
  always_ff @(posedge clk) begin
    if (rst) begin
      irda_sir_sel <= 1'b1;
      tx_allow     <= 1'b1;
      rx_sample_en <= 1'b1;
      rx_flush     <= 1'b0;
    end else begin
      // R1: zero selects sir
      irda_sir_sel <= ~efc_d[rs485_ctrl_pkg::IRDA_MODE_BIT];
      // R4: no new character loads
      tx_allow     <= ~efc_d[rs485_ctrl_pkg::TX_OFF_BIT];
      // R7: multidrop keeps sampling
      // R5: receiver stops at once
      rx_sample_en <= efc_d[rs485_ctrl_pkg::MULTIDROP_BIT] | ~efc_d[rs485_ctrl_pkg::RX_OFF_BIT];
      // R5: flush held character
      rx_flush     <= efc_d[rs485_ctrl_pkg::RX_OFF_BIT] & ~efc_q[rs485_ctrl_pkg::RX_OFF_BIT] &
                      ~efc_d[rs485_ctrl_pkg::MULTIDROP_BIT];
    end
  end

  // receiver state for status, whichever mode owns it
  assign rx_active = (efc_q[rs485_ctrl_pkg::MULTIDROP_BIT] && ctl_q[rs485_ctrl_pkg::SPECIAL_EN_BIT]) ?
                     auto_on : ~efc_q[rs485_ctrl_pkg::RX_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // direction control and receive filter

  // R2: polarity and ownership
  rs485_dir_ctrl u_dir (
    .clk           (clk),
    .rst           (rst),
    .tx_push       (tx_push),
    .tx_fifo_empty (tx_fifo_empty),
    .tx_shift_busy (tx_shift_busy),
    .dir_en        (efc_q[rs485_ctrl_pkg::DIR_CTRL_BIT]),
    .invert        (efc_q[rs485_ctrl_pkg::DIR_INVERT_BIT]),
    .modem_rts     (ctl_q[rs485_ctrl_pkg::MODEM_RTS_BIT]),
    .hw_flow_en    (ctl_q[rs485_ctrl_pkg::HW_FLOW_BIT]),
    .flow_rts_n    (flow_rts_n),
    .rts_n_q       (rts_n),
    .tx_pend_q     (tx_pend)
  );

  // a software receiver-off write also ends the auto address session
  multidrop_filter u_filter (
    .clk        (clk),
    .rst        (rst),
    .rx_valid   (rx_valid),
    .rx_char    (rx_char),
    .rx_par_err (rx_par_err),
    .multidrop  (efc_q[rs485_ctrl_pkg::MULTIDROP_BIT]),
    .special_en (ctl_q[rs485_ctrl_pkg::SPECIAL_EN_BIT]),
    .rx_off     (efc_q[rs485_ctrl_pkg::RX_OFF_BIT]),
    .line_ie    (ctl_q[rs485_ctrl_pkg::LINE_IE_BIT]),
    .match_char (match_q),
    .auto_clear (soft_rst | (efc_d[rs485_ctrl_pkg::RX_OFF_BIT] & ~efc_q[rs485_ctrl_pkg::RX_OFF_BIT])),
    .push_q     (rx_push),
    .entry_q    (rx_entry),
    .line_evt_q (line_evt),
    .special_q  (special_evt),
    .addr_q     (addr_evt),
    .auto_on_q  (auto_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence efc_write_s(logic [7:0] v);
    wr_acc && paddr == rs485_ctrl_pkg::EFC_OFFSET && pwdata[7:0] == v && !soft_rst;
  endsequence

  sequence apb_access_s;
    psel && penable && !pready;
  endsequence

  apb_one_wait_a: assert property (apb_access_s ##0 (psel && penable) |=> pready ##1 !pready)
    else $error("apb ready not exactly one wait state");
  reserved_zero_a: assert property (efc_q[6] == 1'b0 && efc_q[3] == 1'b0) // R22
    else $error("reserved control bits not zero");
  soft_clear_a: assert property (soft_rst |=> efc_q == 8'h00) // R23
    else $error("soft reset did not clear control register");
  irda_sel_a: assert property (wr_acc && paddr == rs485_ctrl_pkg::EFC_OFFSET && !soft_rst |=> irda_sir_sel == !$past(pwdata[7])) // R1
    else $error("infrared select does not follow bit 7");
  tx_gate_a: assert property (wr_acc && paddr == rs485_ctrl_pkg::EFC_OFFSET && !soft_rst |=> tx_allow == !$past(pwdata[2])) // R4
    else $error("transmit gate disagrees with transmitter_off");
  rx_flush_a: assert property (efc_write_s(8'h02) ##0 !efc_q[1] && !efc_q[0] |=> rx_flush && !rx_sample_en) // R5
    else $error("receiver off did not stop and flush");
  rts_modem_a: assert property (!efc_q[4] && !ctl_q[1] && $stable(ctl_q) && $stable(efc_q) |=> rts_n == !$past(ctl_q[0])) // R8
    else $error("rts does not follow modem bit");
  rts_owner_a: assert property (efc_q[4] && $past(efc_q[4]) && !tx_pend && !tx_push |-> rts_n == !$past(efc_q[5])) // R2
    else $error("idle rts level wrong for polarity");
  host_addr_a: assert property (rx_valid && efc_q[0] && !ctl_q[2] && rx_char.ninth |=> rx_push && rx_entry.parity_err) // R17
    else $error("address byte not stored with parity error");
  line_evt_a: assert property (rx_valid && efc_q[0] && rx_char.ninth && ctl_q[3] && !ctl_q[2] |=> line_evt) // R12
    else $error("address byte did not raise line status event");
  special_set_a: assert property (special_evt |=> special_flag_q) // R21
    else $error("special character flag lost");

endmodule : rs485_multidrop_ctrl

// ==== tb/station_model.sv ====
// remote multidrop station model feeding received characters into the block
module station_model (
  input  wire logic                clk,        // core clock
  output logic                     rx_valid,   // character complete
  output rs485_ctrl_pkg::rx_char_s rx_char,    // ninth bit and data
  output logic                     rx_par_err  // core parity result
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line: no character, pattern left unknown-free
  initial begin
    rx_valid   = 1'b0;
    rx_char    = '0;
    rx_par_err = 1'b0;
  end

  // ninth bit marks address, forced-zero parity fails on it
  task automatic send(input logic nb, input logic [7:0] d);
    @(posedge clk);
    rx_valid   <= 1'b1;
    rx_char    <= {nb, d};
    rx_par_err <= nb;
    @(posedge clk);
    rx_valid   <= 1'b0;
    // released character shows its inverse so stale data is never mistaken for fresh
    rx_char    <= ~{nb, d};
    rx_par_err <= ~nb;
  endtask : send
endmodule : station_model

// ==== tb/uart_rs485_multidrop_control_tb.sv ====
// self-checking bench for the rs-485 direction and multidrop control block
module uart_rs485_multidrop_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, psel, penable, pwrite, tx_push, tx_fifo_empty, tx_shift_busy, flow_rts_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rts_n, irda_sir_sel, tx_allow, rx_sample_en, rx_flush, rx_push, line_evt;
  logic        rx_valid, rx_par_err;
  rs485_ctrl_pkg::rx_char_s  rx_char;
  rs485_ctrl_pkg::rx_entry_s rx_entry;
  int          err_count, num_checks, cycles;

  rs485_multidrop_ctrl u_rs485_multidrop_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_push(tx_push), .tx_fifo_empty(tx_fifo_empty), .tx_shift_busy(tx_shift_busy), .flow_rts_n(flow_rts_n),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_par_err(rx_par_err), .rts_n(rts_n), .irda_sir_sel(irda_sir_sel),
    .tx_allow(tx_allow), .rx_sample_en(rx_sample_en), .rx_flush(rx_flush), .rx_push(rx_push),
    .rx_entry(rx_entry), .line_evt(line_evt));
  station_model u_station_model (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char), .rx_par_err(rx_par_err));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard: a stuck handshake ends the run as a mismatch
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  // apb transfer: request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(r === exp && e === eerr, "register read");
  endtask : rd_chk
  task automatic rx(input logic nb, input logic [7:0] d, input logic push, input logic perr, input logic evt);
    u_station_model.send(nb, d);
    #1;
    chk(rx_push === push && line_evt === evt, "receive push or line event");
    if (push) chk(rx_entry === {perr, d}, "receive entry");
  endtask : rx
  // one transmit burst: pushed, then shifting, then idle
  task automatic tx_burst(input logic act, input logic idle);
    @(posedge clk);
    tx_push       <= 1'b1;
    tx_fifo_empty <= 1'b0;
    @(posedge clk);
    tx_push       <= 1'b0;
    tx_fifo_empty <= 1'b1;
    tx_shift_busy <= 1'b1;
    #1 chk(rts_n === act, "rts on push");
    @(posedge clk);
    tx_shift_busy <= 1'b0;
    #1 chk(rts_n === act, "rts while shifting");
    @(posedge clk);
    #1 chk(rts_n === idle, "rts after last bit");
  endtask : tx_burst

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    rd_chk(rs485_ctrl_pkg::EFC_OFFSET, 32'h00000000, 1'b0);
    chk(rts_n === 1'b1 && irda_sir_sel === 1'b1 && tx_allow === 1'b1, "reset outputs");
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'hff);
    chk(irda_sir_sel === 1'b0 && tx_allow === 1'b0, "gates after write");
    rd_chk(rs485_ctrl_pkg::EFC_OFFSET, 32'h000000b7, 1'b0);
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h80);
    rd_chk(rs485_ctrl_pkg::EFC_OFFSET, 32'h00000000, 1'b0);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h02);
    chk(rx_flush === 1'b1 && rx_sample_en === 1'b0, "receiver off flush");
    rd_chk(8'h10, 32'h00000000, 1'b1);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h00);
  endtask : test_regs
  task automatic test_rts;
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h02);
    @(posedge clk);
    #1 chk(rts_n === 1'b0, "flow control drives rts");
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h10);
    @(posedge clk);
    #1 chk(rts_n === 1'b1, "transmitter overrides flow rts");
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h00);
    tx_burst(1'b0, 1'b1);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h30);
    @(posedge clk);
    #1 chk(rts_n === 1'b0, "inverted idle rts");
    tx_burst(1'b1, 1'b0);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h00);
  endtask : test_rts
  task automatic test_multidrop;
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h08);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h03);
    rx(1'b0, 8'h11, 1'b0, 1'b0, 1'b0);
    rx(1'b1, 8'h2a, 1'b1, 1'b1, 1'b1);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h01);
    rx(1'b0, 8'h33, 1'b1, 1'b0, 1'b0);
    rx(1'b1, 8'h2b, 1'b1, 1'b1, 1'b1);
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h0c);
    wr(rs485_ctrl_pkg::MATCH_OFFSET, 8'h42);
    wr(rs485_ctrl_pkg::CTL_OFFSET, 8'h8c);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h01);
    rx(1'b0, 8'h10, 1'b0, 1'b0, 1'b0);
    rx(1'b1, 8'h55, 1'b0, 1'b0, 1'b0);
    rx(1'b1, 8'h42, 1'b1, 1'b1, 1'b1);
    rx(1'b0, 8'h20, 1'b1, 1'b0, 1'b0);
    rx(1'b1, 8'h55, 1'b0, 1'b0, 1'b0);
    rx(1'b0, 8'h21, 1'b0, 1'b0, 1'b0);
    rx(1'b1, 8'h42, 1'b1, 1'b1, 1'b1);
    wr(rs485_ctrl_pkg::EFC_OFFSET, 8'h00);
    rx(1'b0, 8'h42, 1'b1, 1'b0, 1'b0);
    rd_chk(rs485_ctrl_pkg::STATUS_OFFSET, 32'h0000001b, 1'b0);
    wr(rs485_ctrl_pkg::STATUS_OFFSET, 8'h18);
    rd_chk(rs485_ctrl_pkg::STATUS_OFFSET, 32'h00000003, 1'b0);
  endtask : test_multidrop

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset held twelve cycles, then each scenario in turn
  initial begin
    {psel, penable, pwrite, tx_push, tx_shift_busy} = '0;
    {paddr, pwdata} = '0;
    tx_fifo_empty = 1'b1;
    flow_rts_n = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_rts();
    test_multidrop();
    complete_run();
  end
endmodule : uart_rs485_multidrop_control_tb
